//--- core/tpse_pkg.sv
// Constants, register map and carrier types of the PWM timer block.
// Assumes an AXI4-Lite master and a port/event fabric on one clock.
package tpse_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CTRLA = 6'h00;
  localparam logic [5:0] IDX_CTRLB = 6'h01;
  localparam logic [5:0] IDX_CTRLD = 6'h03;
  localparam logic [5:0] IDX_CTRLECLR = 6'h04;
  localparam logic [5:0] IDX_CONTROL_E_SET_REGISTER = 6'h05;
  localparam logic [5:0] IDX_CTRLFCLR = 6'h06;
  localparam logic [5:0] IDX_CTRLFSET = 6'h07;
  localparam logic [5:0] IDX_EVCTRL = 6'h09;
  localparam logic [5:0] IDX_FLAGS = 6'h0b;
  localparam logic [5:0] IDX_CNT = 6'h20;
  localparam logic [5:0] IDX_PER = 6'h26;
  localparam logic [5:0] IDX_CMP0 = 6'h28;
  localparam logic [5:0] IDX_PERBUF = 6'h36;
  localparam logic [5:0] IDX_CMP0BUF = 6'h38;
  localparam logic [5:0] IDX_STEP = 6'h02;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CA_EN = 0;
  localparam int CA_PSC = 1;
  localparam int CB_WG = 0;
  localparam int CB_CHEN = 4;
  localparam int CD_SPLIT = 0;
  localparam int CE_DIR = 0;
  localparam int CE_LOCK_UPDATE = 1;
  localparam int CE_CMD = 2;
  localparam int EV_COUNT_ON_EVENT_ENABLE = 0;
  localparam int EV_ACT = 1;
  localparam int FL_OVF = 0;
  localparam int FL_HIGH_UNDERFLOW_EVENT = 1;
  localparam int FL_CMP = 4;
  localparam int CW = 16;
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] WG_NORMAL = 3'h0;
  localparam logic [2:0] WG_FRQ = 3'h1;
  localparam logic [2:0] WG_SS = 3'h3;
  localparam logic [2:0] WG_DSTOP = 3'h5;
  localparam logic [2:0] WG_DSBOTH = 3'h6;
  localparam logic [2:0] WG_DSBOT = 3'h7;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_UPDATE = 2'h1;
  localparam logic [1:0] CMD_RESTART = 2'h2;
  localparam logic [1:0] CMD_RESET = 2'h3;
  localparam logic [2:0] EA_POSEDGE = 3'h0;
  localparam logic [2:0] EA_ANYEDGE = 3'h1;
  localparam logic [2:0] EA_HIGH = 3'h2;
  localparam logic [2:0] EA_UPDOWN = 3'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] PER_RST = 16'hffff;

  typedef struct packed {
    logic overflow_low_underflow_event;
    logic high_underflow_event;
    logic [2:0] cmp;
  } tpse_evt_s;

  // Prescaler divide minus one for each select code
  function automatic logic [9:0] tpse_psc_max(input logic [2:0] sel);
    case (sel)
      3'h0: return 10'h000;
      3'h1: return 10'h001;
      3'h2: return 10'h003;
      3'h3: return 10'h007;
      3'h4: return 10'h00f;
      3'h5: return 10'h03f;
      3'h6: return 10'h0ff;
      default: return 10'h3ff;
    endcase
  endfunction
endpackage

//--- core/tpse_timer.sv
// 16-bit PWM timer with split mode, commands and events.
// Assumes port direction/output/invert come from port logic on
// core_clk_in; event input is synchronous to core_clk_in.
//
// Overview of operation
// - Frequency mode, compare zero toggles every clock
// - Single slope: count to period, set/clear output
// - Single slope compare zero low, above period high
// - Single slope period plus one ticks per cycle
// - Dual slope up/down, clear rising, set falling
// - Dual slope compare zero low, equal period high
// - Dual slope cycle lasts twice period ticks
// - Pin override needs enable, output direction, and mode unless split
// - Commands written to control E set register
// - Update command ignores lock update bit
// - Restart clears counter, direction, compare outputs
// - Reset command only while disabled, restores registers
// - Split: two 8-bit down counters, three channels each
// - Split: high underflow flag, no high compare flags
// - Split: buffers unused, byte access to registers
// - Mode switch keeps register contents unchanged
// - Pulse events for overflow, underflow, compare matches
// - Events fire exactly when flags are raised
// - Event input counts or steers per action field
// - Split mode ignores event input entirely
// - Update at top or bottom unless locked
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module tpse_timer
  import tpse_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic event_in,
  output tpse_evt_s event_out,
  input wire logic [5:0] port_out_in,
  input wire logic [5:0] port_dir_in,
  input wire logic [5:0] pin_invert_enable_in,
  output logic [5:0] pin_out
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic en_q, split_enable_q, dir_q, lock_update_q, count_on_event_enable_q;
  logic [2:0] clock_prescale_select_q, waveform_mode_select_q;
  logic [2:0] event_action_select_q;
  logic [6:0] chen_q;
  logic [3:0] bv_q;
  logic [7:0] flags_q;
  logic [15:0] counter_value_q, per_q, perbuf_q;
  logic [15:0] compare_value_q [3];
  logic [15:0] cmpbuf_q [3];
  logic [5:0] wave_q;
  logic [9:0] psc_q;
  logic ev_q;
  tpse_evt_s evt_d;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_q, w_q, bvalid_q, rvalid_q;
  logic [5:0] awidx_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_wr;

  function automatic logic mapped(input logic [5:0] i);
    return i inside {IDX_CTRLA, IDX_CTRLB, IDX_CTRLD, IDX_CTRLECLR,
      IDX_CONTROL_E_SET_REGISTER, IDX_CTRLFCLR, IDX_CTRLFSET, IDX_EVCTRL, IDX_FLAGS,
      IDX_CNT, IDX_PER, IDX_PERBUF, IDX_CMP0, IDX_CMP0 + IDX_STEP,
      IDX_CMP0 + IDX_STEP + IDX_STEP, IDX_CMP0BUF, IDX_CMP0BUF + IDX_STEP,
      IDX_CMP0BUF + IDX_STEP + IDX_STEP};
  endfunction

  assign s_axi_awready_out = !aw_q && !bvalid_q;
  assign s_axi_wready_out = !w_q && !bvalid_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
  assign do_wr = aw_q && w_q && !bvalid_q;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      awidx_q <= 6'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_q <= 1'b1;
        awidx_q <= s_axi_awaddr_in[7:2];
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= mapped(awidx_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old);
    return {wstrb_q[1] ? wdata_q[15:8] : old[15:8],
            wstrb_q[0] ? wdata_q[7:0] : old[7:0]};
  endfunction

  function automatic logic wr_at(input logic [5:0] i, input logic b);
    return do_wr && awidx_q == i && wstrb_q[0] | (b & wstrb_q[1]);
  endfunction

  logic [1:0] cmd;
  logic cmd_upd, cmd_restart, cmd_reset, cnt_wr;
  assign cmd = wdata_q[CE_CMD +: 2];
  assign cmd_upd = wr_at(IDX_CONTROL_E_SET_REGISTER, 1'b0) && cmd == CMD_UPDATE;
  assign cmd_restart = wr_at(IDX_CONTROL_E_SET_REGISTER, 1'b0) && cmd == CMD_RESTART;
  assign cmd_reset = wr_at(IDX_CONTROL_E_SET_REGISTER, 1'b0) && cmd == CMD_RESET
                     && !en_q;
  assign cnt_wr = do_wr && awidx_q == IDX_CNT && |wstrb_q[1:0];

  logic [31:0] rd;
  always_comb begin
    rd = 32'h0000_0000;
    unique case (s_axi_araddr_in[7:2])
      IDX_CTRLA: rd[3:0] = {clock_prescale_select_q, en_q};
      IDX_CTRLB: rd[6:0] = {chen_q[6:4], 1'b0, waveform_mode_select_q};
      IDX_CTRLD: rd[CD_SPLIT] = split_enable_q;
      IDX_CTRLECLR, IDX_CONTROL_E_SET_REGISTER: rd[1:0] = {lock_update_q, dir_q};
      IDX_CTRLFCLR, IDX_CTRLFSET: rd[3:0] = bv_q;
      IDX_EVCTRL: rd[3:0] = {event_action_select_q, count_on_event_enable_q};
      IDX_FLAGS: rd[7:0] = flags_q;
      IDX_CNT: rd[15:0] = counter_value_q;
      IDX_PER: rd[15:0] = per_q;
      IDX_PERBUF: rd[15:0] = perbuf_q;
      default: begin
        for (int n = 0; n < 3; n++) begin
          if (s_axi_araddr_in[7:2] == IDX_CMP0 + 6'(2 * n))
            rd[15:0] = compare_value_q[n];
          if (s_axi_araddr_in[7:2] == IDX_CMP0BUF + 6'(2 * n))
            rd[15:0] = cmpbuf_q[n];
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid_in && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd;
      rresp_q <= mapped(s_axi_araddr_in[7:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_q <= 1'b0;
      clock_prescale_select_q <= 3'h0;
      waveform_mode_select_q <= WG_NORMAL;
      chen_q <= 7'h00;
      split_enable_q <= 1'b0;
      lock_update_q <= 1'b0;
      count_on_event_enable_q <= 1'b0;
      event_action_select_q <= EA_POSEDGE;
    end else if (cmd_reset) begin
      en_q <= 1'b0;
      clock_prescale_select_q <= 3'h0;
      waveform_mode_select_q <= WG_NORMAL;
      chen_q <= 7'h00;
      split_enable_q <= 1'b0;
      lock_update_q <= 1'b0;
      count_on_event_enable_q <= 1'b0;
      event_action_select_q <= EA_POSEDGE;
    end else if (do_wr && wstrb_q[0]) begin
      // Mode bit only changes meaning, never content
      unique case (awidx_q)
        IDX_CTRLA: {clock_prescale_select_q, en_q} <= wdata_q[3:0];
        IDX_CTRLB: begin
          chen_q <= wdata_q[6:0];
          waveform_mode_select_q <= wdata_q[CB_WG +: 3];
        end
        IDX_CTRLD: split_enable_q <= wdata_q[CD_SPLIT];
        IDX_CTRLECLR:
          if (wdata_q[CE_LOCK_UPDATE]) lock_update_q <= 1'b0;
        IDX_CONTROL_E_SET_REGISTER:
          if (wdata_q[CE_LOCK_UPDATE]) lock_update_q <= 1'b1;
        IDX_EVCTRL: begin
          count_on_event_enable_q <= wdata_q[EV_COUNT_ON_EVENT_ENABLE];
          event_action_select_q <= wdata_q[EV_ACT +: 3];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and count step
  // ----------------------------------------------------------------
  logic tick, step, ev_on, up;
  logic [15:0] top;
  logic dual;
  // Greater-or-equal so a prescale drop never stalls the divider
  assign tick = en_q && psc_q >= tpse_psc_max(clock_prescale_select_q);
  assign ev_on = count_on_event_enable_q && !split_enable_q;
  assign top = waveform_mode_select_q == WG_FRQ ? compare_value_q[0]
                                                 : per_q;
  assign dual = waveform_mode_select_q >= WG_DSTOP;

  always_comb begin
    step = tick;
    up = !dir_q;
    if (ev_on) begin
      unique case (event_action_select_q)
        EA_POSEDGE: step = en_q && event_in && !ev_q;
        EA_ANYEDGE: step = en_q && (event_in ^ ev_q);
        EA_HIGH: step = tick && event_in;
        EA_UPDOWN: up = !event_in;
        default: step = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      psc_q <= 10'h000;
      ev_q <= 1'b0;
    end else begin
      ev_q <= event_in;
      if (!en_q || tick || cmd_restart)
        psc_q <= 10'h000;
      else
        psc_q <= psc_q + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Next count, events and waveforms
  // ----------------------------------------------------------------
  logic [15:0] cnt_d;
  logic dir_d, at_top, at_bot, upd_nat, lunf, high_underflow_event;
  logic [2:0] mt;
  logic [5:0] wave_d;

  always_comb begin
    cnt_d = counter_value_q;
    dir_d = dir_q;
    at_top = 1'b0;
    at_bot = 1'b0;
    lunf = 1'b0;
    high_underflow_event = 1'b0;
    mt = 3'h0;
    wave_d = wave_q;
    if (split_enable_q) begin
      if (tick) begin
        at_bot = 1'b1;
        if (counter_value_q[7:0] == 8'h00) begin
          cnt_d[7:0] = per_q[7:0];
          lunf = 1'b1;
        end else
          cnt_d[7:0] = counter_value_q[7:0] - 8'h01;
        if (counter_value_q[15:8] == 8'h00) begin
          cnt_d[15:8] = per_q[15:8];
          high_underflow_event = 1'b1;
        end else
          cnt_d[15:8] = counter_value_q[15:8] - 8'h01;
        for (int n = 0; n < 3; n++) begin
          mt[n] = cnt_d[7:0] == compare_value_q[n][7:0];
          wave_d[n] = cnt_d[7:0] < compare_value_q[n][7:0];
          wave_d[n + 3] = cnt_d[15:8] < compare_value_q[n][15:8];
        end
      end
    end else if (step) begin
      if (dual) begin
        if (up && counter_value_q >= top) begin
          dir_d = 1'b1;
          at_top = 1'b1;
          cnt_d = counter_value_q - 16'h0001;
        end else if (!up && counter_value_q == 16'h0000) begin
          dir_d = 1'b0;
          at_bot = 1'b1;
          cnt_d = 16'h0001;
        end else
          cnt_d = up ? counter_value_q + 16'h0001
                     : counter_value_q - 16'h0001;
      end else if (up) begin
        at_top = counter_value_q == top;
        cnt_d = at_top ? 16'h0000 : counter_value_q + 16'h0001;
      end else begin
        at_bot = counter_value_q == 16'h0000;
        cnt_d = at_bot ? top : counter_value_q - 16'h0001;
      end
      for (int n = 0; n < 3; n++) begin
        mt[n] = cnt_d == compare_value_q[n];
        unique case (waveform_mode_select_q)
          WG_FRQ: wave_d[n] = wave_q[n] ^ mt[n];
          WG_SS: wave_d[n] = cnt_d < compare_value_q[n];
          WG_DSTOP, WG_DSBOTH, WG_DSBOT:
            wave_d[n] = compare_value_q[n] != 16'h0000 &&
              (compare_value_q[n] >= top ||
               cnt_d < compare_value_q[n] ||
               (dir_d && cnt_d == compare_value_q[n]));
          default: ;
        endcase
      end
    end
    evt_d.cmp = mt;
    evt_d.high_underflow_event = high_underflow_event;
    unique case (waveform_mode_select_q)
      WG_DSTOP: evt_d.overflow_low_underflow_event = at_top;
      WG_DSBOT: evt_d.overflow_low_underflow_event = at_bot;
      default: evt_d.overflow_low_underflow_event = at_top || at_bot;
    endcase
    if (split_enable_q) evt_d.overflow_low_underflow_event = lunf;
    upd_nat = !split_enable_q && (dual ? at_bot : at_top || at_bot);
  end

  // ----------------------------------------------------------------
  // Counter, direction and waveform state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      counter_value_q <= CNT_RST;
      dir_q <= 1'b0;
      wave_q <= 6'h00;
    end else if (cmd_reset || cmd_restart) begin
      counter_value_q <= CNT_RST;
      dir_q <= 1'b0;
      wave_q <= 6'h00;
    end else begin
      counter_value_q <= cnt_wr ? merge(counter_value_q) : cnt_d;
      wave_q <= wave_d;
      if (wr_at(IDX_CTRLECLR, 1'b0) && wdata_q[CE_DIR])
        dir_q <= 1'b0;
      else if (wr_at(IDX_CONTROL_E_SET_REGISTER, 1'b0) && wdata_q[CE_DIR])
        dir_q <= 1'b1;
      else
        dir_q <= dir_d;
    end
  end

  // ----------------------------------------------------------------
  // Period, compare and buffers
  // ----------------------------------------------------------------
  logic upd;
  assign upd = cmd_upd || (upd_nat && !lock_update_q);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      per_q <= PER_RST;
      perbuf_q <= PER_RST;
      bv_q <= 4'h0;
      for (int n = 0; n < 3; n++) begin
        compare_value_q[n] <= CNT_RST;
        cmpbuf_q[n] <= CNT_RST;
      end
    end else if (cmd_reset) begin
      per_q <= PER_RST;
      perbuf_q <= PER_RST;
      bv_q <= 4'h0;
      for (int n = 0; n < 3; n++) begin
        compare_value_q[n] <= CNT_RST;
        cmpbuf_q[n] <= CNT_RST;
      end
    end else begin
      if (upd && !split_enable_q) begin
        if (bv_q[0]) per_q <= perbuf_q;
        for (int n = 0; n < 3; n++)
          if (bv_q[n + 1]) compare_value_q[n] <= cmpbuf_q[n];
        bv_q <= 4'h0;
      end
      if (wr_at(IDX_CTRLFCLR, 1'b0)) bv_q <= bv_q & ~wdata_q[3:0];
      if (wr_at(IDX_CTRLFSET, 1'b0)) bv_q <= bv_q | wdata_q[3:0];
      if (wr_at(IDX_PER, 1'b1)) per_q <= merge(per_q);
      if (wr_at(IDX_PERBUF, 1'b1)) begin
        perbuf_q <= merge(perbuf_q);
        bv_q[0] <= 1'b1;
      end
      for (int n = 0; n < 3; n++) begin
        if (wr_at(IDX_CMP0 + 6'(2 * n), 1'b1))
          compare_value_q[n] <= merge(compare_value_q[n]);
        if (wr_at(IDX_CMP0BUF + 6'(2 * n), 1'b1)) begin
          cmpbuf_q[n] <= merge(cmpbuf_q[n]);
          bv_q[n + 1] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags and event pulses
  // ----------------------------------------------------------------
  logic [7:0] fset;
  always_comb begin
    fset = 8'h00;
    fset[FL_OVF] = evt_d.overflow_low_underflow_event;
    fset[FL_HIGH_UNDERFLOW_EVENT] = evt_d.high_underflow_event;
    fset[FL_CMP +: 3] = evt_d.cmp;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_q <= 8'h00;
      event_out <= '0;
    end else begin
      event_out <= evt_d;
      if (cmd_reset)
        flags_q <= 8'h00;
      else if (wr_at(IDX_FLAGS, 1'b0))
        flags_q <= (flags_q & ~wdata_q[7:0]) | fset;
      else
        flags_q <= flags_q | fset;
    end
  end

  // ----------------------------------------------------------------
  // Port pin override
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_out <= 6'h00;
    end else begin
      for (int n = 0; n < 6; n++) begin
        if (port_dir_in[n] && (split_enable_q ? chen_q[n < 3 ? n + 4 : n - 3]
            : n < 3 && chen_q[CB_CHEN + n % 3] &&
              waveform_mode_select_q != WG_NORMAL))
          pin_out[n] <= wave_d[n] ^ pin_invert_enable_in[n];
        else
          pin_out[n] <= port_out_in[n];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_frq_fast;
    en_q && waveform_mode_select_q == WG_FRQ && !split_enable_q &&
    compare_value_q[0] == 16'h0000 && clock_prescale_select_q == 3'h0 &&
    !count_on_event_enable_q && !do_wr && counter_value_q == CNT_RST;
  endsequence
  a_frq_half_rate: assert property (s_frq_fast [*2] |->
    wave_q[0] != $past(wave_q[0])) else $error("no toggle");
  a_ss_wrap_zero: assert property (step && !split_enable_q && !cnt_wr &&
    waveform_mode_select_q == WG_SS && up && !cmd_restart &&
    counter_value_q == per_q |=> counter_value_q == 16'h0000)
    else $error("no wrap at period");
  a_ss_cmp_zero: assert property (step && !split_enable_q &&
    waveform_mode_select_q == WG_SS && compare_value_q[0] == 16'h0000
    && !cmd_restart |=> !wave_q[0]) else $error("zero not low");
  a_ds_cmp_top: assert property (step && !split_enable_q && dual &&
    compare_value_q[0] == per_q && per_q != 16'h0000 && !cmd_restart
    |=> wave_q[0]) else $error("top not high");
  sequence s_restart;
    cmd_restart;
  endsequence
  a_restart_clear: assert property (s_restart |=> counter_value_q ==
    16'h0000 && !dir_q && wave_q == 6'h00) else $error("restart");
  a_reset_guard: assert property (en_q && wr_at(IDX_CONTROL_E_SET_REGISTER, 1'b0) &&
    cmd == CMD_RESET && !wr_at(IDX_CTRLA, 1'b0) |=> en_q)
    else $error("reset while enabled");
  a_update_cmd: assert property (cmd_upd && bv_q[0] && !split_enable_q &&
    !wr_at(IDX_PER, 1'b1) |=> per_q == $past(perbuf_q))
    else $error("update cmd");
  a_lock_hold: assert property (upd_nat && lock_update_q && !cmd_upd &&
    !do_wr |=> $stable(per_q)) else $error("locked update");
  a_split_no_ev: assert property (
    split_enable_q && !tick && !cnt_wr && !cmd_restart && !cmd_reset
    |=> $stable(counter_value_q)) else $error("event in split");
  a_evt_flag: assert property (event_out.cmp[0] |-> flags_q[FL_CMP])
    else $error("event without flag");
endmodule

//--- tb/tpse_port_model.sv
// Port pins and event fabric seen from the timer.
// Assumes the bench steers the event level on core_clk_in.
`timescale 1ns/1ps
module tpse_port_model (
  input wire logic core_clk_in,
  input wire logic ev_level_in,
  input wire logic [5:0] dir_mask_in,
  output logic event_out,
  output logic [5:0] port_out_out,
  output logic [5:0] port_dir_out,
  output logic [5:0] pin_invert_enable_out
);
  assign port_out_out = 6'h2a;
  assign port_dir_out = dir_mask_in;
  assign pin_invert_enable_out = 6'h00;
  // Event fabric is synchronous to the timer clock
  always_ff @(posedge core_clk_in) event_out <= ev_level_in;
endmodule

//--- tb/tpse_timer_tb.sv
// Self-checking bench for the PWM timer block.
// Assumes AXI4-Lite register access and the port/event model.
`timescale 1ns/1ps
module tpse_timer_tb;
  import tpse_pkg::*;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0;
  logic rre = 0, ev = 0, awr, wrd, bv, arr, rv, evi;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0] br, rr;
  logic [5:0] pin, po, pd, pi;
  logic [5:0] dm = 6'h3f;
  logic [3:0] ws = 4'hf;
  tpse_evt_s evo;
  int n_mismatch = 0, n_checks = 0, hi, hi3, tg, ov, c0, hu;
  int sc[3] = '{0, 1, 5}, sh[3] = '{0, 3, 12}, sm[3] = '{3, 3, 0};
  int dc[3] = '{0, 1, 3}, dh[3] = '{0, 4, 12}, ee[3] = '{3, 6, 6};
  tpse_timer u_dut (.core_clk_in(clk), .rst_n_in(rst_n),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrd), .s_axi_bresp_out(br),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rre), .event_in(evi), .event_out(evo),
    .port_out_in(po), .port_dir_in(pd), .pin_invert_enable_in(pi),
    .pin_out(pin));
  tpse_port_model u_port (.core_clk_in(clk), .ev_level_in(ev),
    .dir_mask_in(dm), .event_out(evi), .port_out_out(po),
    .port_dir_out(pd),
    .pin_invert_enable_out(pi));
  initial forever #2 clk = ~clk;
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [15:0] d);
    logic a, w, b;
    @(posedge clk);
    awa <= {i, 2'b00};
    wd <= {16'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      a = awv && awr;
      w = wv && wrd;
      b = bv && bre;
      @(posedge clk);
      if (a) awv <= 1'b0;
      if (w) wv <= 1'b0;
    end
    bre <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] i, input logic [15:0] e,
                    input logic [1:0] er);
    logic a, r;
    logic [31:0] d;
    logic [1:0] p;
    @(posedge clk);
    ara <= {i, 2'b00};
    arv <= 1'b1;
    rre <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      a = arv && arr;
      r = rv && rre;
      d = rdat;
      p = rr;
      @(posedge clk);
      if (a) arv <= 1'b0;
    end
    rre <= 1'b0;
    chk(d, {16'h0, e});
    chk({30'h0, p}, {30'h0, er});
  endtask
  // Counts pin levels, toggles and event pulses over 12 cycles
  task automatic win();
    logic p;
    hi = 0; hi3 = 0; tg = 0; ov = 0; c0 = 0; hu = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    p = pin[0];
    repeat (12) begin
      @(negedge clk);
      hi += pin[0]; hi3 += pin[3]; tg += (pin[0] != p); p = pin[0];
      ov += evo.overflow_low_underflow_event; hu += evo.high_underflow_event; c0 += evo.cmp[0];
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(IDX_PER, 16'hffff, RESP_OKAY);
    rd(6'h3f, 16'h0, RESP_SLVERR);
    wr(IDX_CMP0, 16'h0); wr(IDX_CTRLB, 16'h11); wr(IDX_CTRLA, 16'h1);
    win(); chk(tg, 12);
    wr(IDX_PER, 16'h3); wr(IDX_CTRLB, 16'h13);
    for (int k = 0; k < 3; k++) begin
      wr(IDX_CMP0, sc[k][15:0]); win();
      chk(hi, sh[k]);
      chk(ov, 3);
      chk(c0, sm[k]);
    end
    wr(IDX_CTRLB, 16'h15);
    for (int k = 0; k < 3; k++) begin
      wr(IDX_CMP0, dc[k][15:0]); win(); chk(hi, dh[k]);
      chk(ov, 2);
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge clk); dm <= k == 2 ? 6'h3e : 6'h3f;
      wr(IDX_CTRLB, k == 0 ? 16'h10 : k == 1 ? 16'h03 : 16'h13); win();
      chk({26'h0, pin}, 32'h2a); chk(hi, 0);
    end
    @(posedge clk); dm <= 6'h3f;
    wr(IDX_CTRLA, 16'h0); wr(IDX_CNT, 16'h5); wr(IDX_CONTROL_E_SET_REGISTER, 16'h8);
    rd(IDX_CNT, 16'h0, RESP_OKAY);
    wr(IDX_CONTROL_E_SET_REGISTER, 16'h2); wr(IDX_PERBUF, 16'h20); wr(IDX_CTRLA, 16'h1);
    repeat (8) @(posedge clk);
    rd(IDX_PER, 16'h3, RESP_OKAY);
    wr(IDX_CONTROL_E_SET_REGISTER, 16'h4); rd(IDX_PER, 16'h20, RESP_OKAY);
    wr(IDX_CONTROL_E_SET_REGISTER, 16'hc); wr(IDX_CTRLA, 16'h0);
    rd(IDX_PER, 16'h20, RESP_OKAY);
    wr(IDX_CONTROL_E_SET_REGISTER, 16'hc); rd(IDX_PER, 16'hffff, RESP_OKAY);
    for (int a = 0; a < 3; a++) begin
      wr(IDX_CONTROL_E_SET_REGISTER, 16'hc); wr(IDX_EVCTRL, 16'(a * 2 + 1));
      wr(IDX_CTRLA, 16'h1);
      repeat (3) begin
        @(posedge clk); ev <= 1'b1;
        repeat (2) @(posedge clk);
        ev <= 1'b0;
        repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      rd(IDX_CNT, ee[a][15:0], RESP_OKAY);
      wr(IDX_CTRLA, 16'h0);
    end
    wr(IDX_CONTROL_E_SET_REGISTER, 16'hc); wr(IDX_EVCTRL, 16'h5);
    wr(IDX_CTRLD, 16'h1); wr(IDX_PER, 16'h0503);
    wr(IDX_CMP0, 16'h0201); wr(IDX_CTRLB, 16'h11); wr(IDX_CTRLA, 16'h1);
    // Event held low: split must count regardless
    win(); chk(hi, 3);
    chk(hi3, 4);
    chk(hu, 2);
    chk(c0, 3);
    @(posedge clk); ws <= 4'h2;
    wr(IDX_PER, 16'h0900); rd(IDX_PER, 16'h0903, RESP_OKAY);
    @(posedge clk); ws <= 4'hf;
    wr(IDX_CTRLA, 16'h0); wr(IDX_CTRLD, 16'h0);
    rd(IDX_PER, 16'h0903, RESP_OKAY);
    final_report();
  end
  initial begin
    #100us;
    n_mismatch++;
    final_report();
  end
endmodule
